/* core/itfd_decoder.sv */
// Input terminal function decoder with APB register slave
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Code 52 asserted ignores pulse reference input
// - Code 53 clears position loop deviation
// - Code 54 selects alternate position gains
// - Code 55 cyclic positioning only in digital positioning
// - Code 56 starts emergency deceleration stop
// - Code 57 is overtemperature fault, stops motor
// - Codes 59/60 switch control mode when stopped
// - Code 61 inverts PID polarity with setting
// - Code 63 enters zero servo when enabled
// - Codes 64/65 forward and reverse max limits
// - Code 66 zeroes position counter
// - Codes 67/69 trim pulses only with 68
// - Code 70 selects second gear numerator
// - Codes 71/72 select role only when stopped
// - Codes 73-79 act only with tension control
// - Codes 80/81 pick initial roll diameter
// - Code 82 raises fire signal in fire mode
// - Code 83 selects second tension PID group
// - Ones digit types fast input A
// - Tens digit types fast input B
// - Per-terminal function select, terminal one forward
module itfd_decoder (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [itfd_pkg::NUM_TERM-1:0] terminalIn,
	input wire logic driveStopped,
	output logic fastInputAPulse,
	output logic fastInputBPulse,
	output logic [itfd_pkg::NUM_TERM-1:0] forwardRotationCmd,
	output logic pulseInhibit,
	output logic clearPosDeviation,
	output logic altPosGain,
	output logic cyclicPosEnable,
	output logic emergencyStop,
	output logic motorOverTempFault,
	output logic [1:0] controlMode,
	output logic pidPolarityInvert,
	output logic zeroServo,
	output logic forwardMaxLimit,
	output logic reverseMaxLimit,
	output logic positionCountClear,
	output logic pulseTrimUp,
	output logic pulseTrimDown,
	output logic secondGearNumerator,
	output logic [1:0] syncRole,
	output logic [6:0] tensionCmd,
	output logic [1:0] initialDiameterSel,
	output logic fireModeSignal,
	output logic tensionPidGroup2
);
	import itfd_pkg::*;

	// ==========================================================
	// Reset release
	logic rstMeta_ff;
	logic rstSync_ff;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end
	wire rstN = rstSync_ff;

	// ==========================================================
	// Registers
	logic [7:0] fastType_ff;
	logic [6:0] funcSel_ff [NUM_TERM];
	logic [7:0] control_ff;
	logic apbWrite;
	logic [NUM_TERM-1:0] level_ff;
	assign apbWrite = psel && penable && pwrite;

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			fastType_ff <= RST_FAST_TYPE;
			control_ff <= RST_CONTROL;
		end else if (apbWrite) begin
			// Only 0 or 1 per digit is legal, so keep one bit per nibble
			if (paddr == OFF_FAST_TYPE) begin
				fastType_ff <= {3'h0, pwdata[FT_B_BIT], 3'h0, pwdata[FT_A_BIT]};
			end
			if (paddr == OFF_CONTROL) begin
				control_ff <= {3'h0, pwdata[4:0]};
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_TERM; gi++) begin : gTerm
			always_ff @(posedge mclk or negedge rstN) begin
				if (!rstN) begin
					funcSel_ff[gi] <= (gi == 0) ? RST_FUNC_TERM1 : RST_FUNC_OTHER;
				end else if (apbWrite && paddr == OFF_FUNC_BASE + 12'(4 * gi)) begin
					funcSel_ff[gi] <= pwdata[6:0];
				end
			end
		end
	endgenerate

	// ==========================================================
	// APB read path, zero-wait answer
	logic [31:0] nxt_prdata;
	logic addrHit;
	always_comb begin
		nxt_prdata = 32'h0;
		addrHit = 1'b0;
		if (paddr == OFF_FAST_TYPE) begin
			nxt_prdata = {24'h0, fastType_ff};
			addrHit = 1'b1;
		end
		if (paddr == OFF_CONTROL) begin
			nxt_prdata = {24'h0, control_ff};
			addrHit = 1'b1;
		end
		if (paddr == OFF_STATUS) begin
			nxt_prdata = {26'h0, syncRole, controlMode, 2'b0};
			addrHit = 1'b1;
		end
		if (paddr == OFF_LEVELS) begin
			nxt_prdata = {26'h0, level_ff};
			addrHit = 1'b1;
		end
		for (int i = 0; i < NUM_TERM; i++) begin
			if (paddr == OFF_FUNC_BASE + 12'(4 * i)) begin
				nxt_prdata = {25'h0, funcSel_ff[i]};
				addrHit = 1'b1;
			end
		end
	end

	// Answer is registered: pready rises the cycle after setup
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addrHit;
			prdata <= (psel && !penable && !pwrite) ? nxt_prdata : 32'h0;
		end
	end

	// ==========================================================
	// Terminal sampling and decode
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			level_ff <= '0;
		end else begin
			level_ff <= terminalIn;
		end
	end

	// Fast input in pulse mode carries no function
	logic [NUM_TERM-1:0] usable;
	always_comb begin
		usable = '1;
		usable[IDX_FAST_A] = fastType_ff[FT_A_BIT];
		usable[IDX_FAST_B] = fastType_ff[FT_B_BIT];
	end

	// One hit bit per function code; reserved codes set a bit that no output reads
	logic [127:0] hit;
	always_comb begin
		hit = '0;
		for (int i = 0; i < NUM_TERM; i++) begin
			if (level_ff[i] && usable[i]) begin
				hit[funcSel_ff[i]] = 1'b1;
			end
		end
	end

	wire tension = control_ff[CTL_TENSION];
	wire superOn = hit[FN_SUPERIMP];

	// ==========================================================
	// Command outputs, one flop process per command
	// Fast inputs come up as pulse inputs until software types them
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			fastInputAPulse <= 1'b1;
		end else begin
			fastInputAPulse <= !fastType_ff[FT_A_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			fastInputBPulse <= 1'b1;
		end else begin
			fastInputBPulse <= !fastType_ff[FT_B_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			forwardRotationCmd <= '0;
		end else begin
			for (int i = 0; i < NUM_TERM; i++) begin
				forwardRotationCmd[i] <= level_ff[i] && usable[i]
					&& funcSel_ff[i] == FN_FWD_RUN;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			pulseInhibit <= 1'b0;
		end else begin
			pulseInhibit <= hit[FN_PULSE_DIS];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			clearPosDeviation <= 1'b0;
		end else begin
			clearPosDeviation <= hit[FN_CLR_DEV];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			altPosGain <= 1'b0;
		end else begin
			altPosGain <= hit[FN_GAIN_SW];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			cyclicPosEnable <= 1'b0;
		end else begin
			cyclicPosEnable <= hit[FN_CYCLIC] && control_ff[CTL_DIGPOS];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			emergencyStop <= 1'b0;
		end else begin
			emergencyStop <= hit[FN_ESTOP];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			motorOverTempFault <= 1'b0;
		end else begin
			motorOverTempFault <= hit[FN_OVERTEMP];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			pidPolarityInvert <= 1'b0;
		end else begin
			pidPolarityInvert <= hit[FN_PID_POL];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			zeroServo <= 1'b0;
		end else begin
			zeroServo <= hit[FN_SERVO] && control_ff[CTL_SERVO_EN];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			forwardMaxLimit <= 1'b0;
		end else begin
			forwardMaxLimit <= hit[FN_FWD_LIM];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			reverseMaxLimit <= 1'b0;
		end else begin
			reverseMaxLimit <= hit[FN_REV_LIM];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			positionCountClear <= 1'b0;
		end else begin
			positionCountClear <= hit[FN_POS_CLR];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			pulseTrimUp <= 1'b0;
		end else begin
			pulseTrimUp <= hit[FN_PULSE_UP] && superOn;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			pulseTrimDown <= 1'b0;
		end else begin
			pulseTrimDown <= hit[FN_PULSE_DN] && superOn;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			secondGearNumerator <= 1'b0;
		end else begin
			secondGearNumerator <= hit[FN_GEAR2];
		end
	end

	// Whole tension group drops at once when tension control is off
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			tensionCmd <= '0;
		end else begin
			tensionCmd <= tension ? hit[FN_FEED_INT:FN_DIA_RST] : 7'h00;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			initialDiameterSel <= '0;
		end else begin
			initialDiameterSel <= tension ? {hit[FN_DIA_SEL1], hit[FN_DIA_SEL0]} : 2'b00;
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			fireModeSignal <= 1'b0;
		end else begin
			fireModeSignal <= hit[FN_FIRE] && control_ff[CTL_FIRE];
		end
	end

	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			tensionPidGroup2 <= 1'b0;
		end else begin
			tensionPidGroup2 <= tension && hit[FN_TPID2];
		end
	end

	// ==========================================================
	// Mode and role latch; only changed while stopped
	always_ff @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			controlMode <= ITFD_MODE_OPEN;
			syncRole <= ITFD_ROLE_NONE;
		end else if (driveStopped && control_ff[CTL_STOPPED] == 1'b0) begin
			// Open loop wins if both are asserted
			if (hit[FN_OPEN_LOOP]) begin
				controlMode <= ITFD_MODE_OPEN;
			end else if (hit[FN_CLOSED_LOOP]) begin
				controlMode <= ITFD_MODE_CLOSED;
			end
			if (hit[FN_MASTER]) begin
				syncRole <= ITFD_ROLE_MASTER;
			end else if (hit[FN_SLAVE]) begin
				syncRole <= ITFD_ROLE_SLAVE;
			end
		end
	end
endmodule

`default_nettype wire

/* core/itfd_pkg.sv */
// Constants and types shared by the input terminal function decoder
package itfd_pkg;
	// ==========================================================
	// Terminal counts and widths
	localparam int NUM_TERM = 6;
	localparam int FUNC_W = 7;
	localparam int IDX_FAST_A = 4;
	localparam int IDX_FAST_B = 5;
	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] OFF_FAST_TYPE = 12'h000;
	localparam logic [11:0] OFF_FUNC_BASE = 12'h004;
	localparam logic [11:0] OFF_CONTROL = 12'h01c;
	localparam logic [11:0] OFF_STATUS = 12'h020;
	localparam logic [11:0] OFF_LEVELS = 12'h024;
	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_FAST_TYPE = 8'h00;
	localparam logic [6:0] RST_FUNC_TERM1 = 7'h01;
	localparam logic [6:0] RST_FUNC_OTHER = 7'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	// ==========================================================
	// Field positions
	localparam int FT_A_BIT = 0;
	localparam int FT_B_BIT = 4;
	localparam int CTL_STOPPED = 0;
	localparam int CTL_DIGPOS = 1;
	localparam int CTL_SERVO_EN = 2;
	localparam int CTL_TENSION = 3;
	localparam int CTL_FIRE = 4;
	// ==========================================================
	// Function codes
	localparam logic [6:0] FN_NONE = 7'h00;
	localparam logic [6:0] FN_FWD_RUN = 7'h01;
	localparam logic [6:0] FN_PULSE_DIS = 7'h34;
	localparam logic [6:0] FN_CLR_DEV = 7'h35;
	localparam logic [6:0] FN_GAIN_SW = 7'h36;
	localparam logic [6:0] FN_CYCLIC = 7'h37;
	localparam logic [6:0] FN_ESTOP = 7'h38;
	localparam logic [6:0] FN_OVERTEMP = 7'h39;
	localparam logic [6:0] FN_OPEN_LOOP = 7'h3b;
	localparam logic [6:0] FN_CLOSED_LOOP = 7'h3c;
	localparam logic [6:0] FN_PID_POL = 7'h3d;
	localparam logic [6:0] FN_SERVO = 7'h3f;
	localparam logic [6:0] FN_FWD_LIM = 7'h40;
	localparam logic [6:0] FN_REV_LIM = 7'h41;
	localparam logic [6:0] FN_POS_CLR = 7'h42;
	localparam logic [6:0] FN_PULSE_UP = 7'h43;
	localparam logic [6:0] FN_SUPERIMP = 7'h44;
	localparam logic [6:0] FN_PULSE_DN = 7'h45;
	localparam logic [6:0] FN_GEAR2 = 7'h46;
	localparam logic [6:0] FN_MASTER = 7'h47;
	localparam logic [6:0] FN_SLAVE = 7'h48;
	localparam logic [6:0] FN_DIA_RST = 7'h49;
	localparam logic [6:0] FN_WIND_SW = 7'h4a;
	localparam logic [6:0] FN_PREDRIVE = 7'h4b;
	localparam logic [6:0] FN_DIA_INH = 7'h4c;
	localparam logic [6:0] FN_ALARM_CLR = 7'h4d;
	localparam logic [6:0] FN_BRAKE = 7'h4e;
	localparam logic [6:0] FN_FEED_INT = 7'h4f;
	localparam logic [6:0] FN_DIA_SEL0 = 7'h50;
	localparam logic [6:0] FN_DIA_SEL1 = 7'h51;
	localparam logic [6:0] FN_FIRE = 7'h52;
	localparam logic [6:0] FN_TPID2 = 7'h53;
	// ==========================================================
	// Control mode and master/slave role
	typedef enum logic [1:0] {
		ITFD_MODE_OPEN = 2'b00,
		ITFD_MODE_CLOSED = 2'b01
	} itfd_mode_t;
	typedef enum logic [1:0] {
		ITFD_ROLE_NONE = 2'b00,
		ITFD_ROLE_MASTER = 2'b01,
		ITFD_ROLE_SLAVE = 2'b10
	} itfd_role_t;
endpackage

/* verification/itfd_switch_model.sv */
// Switch bank model that drives the terminal levels
`timescale 1ns/10ps
`default_nettype none
module itfd_switch_model (
	input wire logic mclk,
	input wire logic [itfd_pkg::NUM_TERM-1:0] want,
	output logic [itfd_pkg::NUM_TERM-1:0] terminalIn
);
	import itfd_pkg::*;
	// Contacts settle one edge after the request
	always_ff @(posedge mclk) begin
		terminalIn <= want;
	end
endmodule
`default_nettype wire

/* verification/itfd_decoder_asserts.sv */
// Port checker for the terminal decoder
`timescale 1ns/10ps
`default_nettype none
module itfd_decoder_chk (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [itfd_pkg::NUM_TERM-1:0] terminalIn,
	input wire logic driveStopped,
	input wire logic fastInputAPulse,
	input wire logic fastInputBPulse,
	input wire logic [itfd_pkg::NUM_TERM-1:0] forwardRotationCmd,
	input wire logic pulseInhibit,
	input wire logic emergencyStop,
	input wire logic [1:0] controlMode,
	input wire logic [1:0] syncRole
);
	import itfd_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	sequence s_ftWr;
		psel && penable && pready && pwrite && paddr == OFF_FAST_TYPE;
	endsequence
	property p_ftA;
		s_ftWr |-> ##2 fastInputAPulse == !$past(pwdata[FT_A_BIT], 2);
	endproperty
	a_ftA: assert property (p_ftA) else $error("fast A type wrong");
	property p_ftB;
		s_ftWr |-> ##2 fastInputBPulse == !$past(pwdata[FT_B_BIT], 2);
	endproperty
	a_ftB: assert property (p_ftB) else $error("fast B type wrong");
	property p_quiet;
		$past(terminalIn) == 0 && $past(terminalIn, 2) == 0 && $past(terminalIn, 3) == 0
			|-> forwardRotationCmd == 0 && !pulseInhibit && !emergencyStop;
	endproperty
	a_quiet: assert property (p_quiet) else $error("command without terminal");
	property p_fwd;
		(forwardRotationCmd & ~($past(terminalIn) | $past(terminalIn, 2)
			| $past(terminalIn, 3))) == 0;
	endproperty
	a_fwd: assert property (p_fwd) else $error("forward run from idle terminal");
	property p_mode;
		$changed(controlMode) |-> $past(driveStopped) || $past(driveStopped, 2);
	endproperty
	a_mode: assert property (p_mode) else $error("mode changed while running");
	property p_role;
		$changed(syncRole) |-> $past(driveStopped) || $past(driveStopped, 2);
	endproperty
	a_role: assert property (p_role) else $error("role changed while running");
	property p_legal;
		syncRole != 2'h3 && controlMode[1] == 1'b0;
	endproperty
	a_legal: assert property (p_legal) else $error("illegal mode or role");
	property p_fgA;
		fastInputAPulse [*3] |-> !forwardRotationCmd[IDX_FAST_A];
	endproperty
	a_fgA: assert property (p_fgA) else $error("pulse input gave command");
endmodule
bind itfd_decoder itfd_decoder_chk u_chk (.mclk, .reset_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .terminalIn, .driveStopped, .fastInputAPulse,
	.fastInputBPulse, .forwardRotationCmd, .pulseInhibit, .emergencyStop,
	.controlMode, .syncRole);
`default_nettype wire

/* verification/input_terminal_function_decoder_bench.sv */
// Self-checking bench for the terminal decoder
`timescale 1ns/10ps
`default_nettype none
module input_terminal_function_decoder_bench;
	import itfd_pkg::*;
	logic mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, driveStopped = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, err, fA, fB;
	logic [5:0] want = 0, tin, forward_rotation;
	logic [9:0] cmd;
	logic [3:0] g;
	logic [1:0] tr, mode, role, dia;
	logic [6:0] tens;
	logic [6:0] codes [13] = '{FN_PULSE_DIS, FN_CLR_DEV, FN_GAIN_SW, FN_ESTOP, FN_OVERTEMP,
		FN_PID_POL, FN_FWD_LIM, FN_REV_LIM, FN_POS_CLR, FN_GEAR2, 7'h3e, 7'h54, 7'h5f};
	int miscompares = 0, compares = 0;
	always #12.5 mclk = ~mclk;
	itfd_switch_model sw (.mclk, .want, .terminalIn(tin));
	itfd_decoder dut (.mclk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .terminalIn(tin), .driveStopped, .fastInputAPulse(fA),
		.fastInputBPulse(fB), .forwardRotationCmd(forward_rotation), .pulseInhibit(cmd[9]),
		.clearPosDeviation(cmd[8]), .altPosGain(cmd[7]), .cyclicPosEnable(g[3]),
		.emergencyStop(cmd[6]), .motorOverTempFault(cmd[5]), .controlMode(mode),
		.pidPolarityInvert(cmd[4]), .zeroServo(g[2]), .forwardMaxLimit(cmd[3]),
		.reverseMaxLimit(cmd[2]), .positionCountClear(cmd[1]), .pulseTrimUp(tr[1]),
		.pulseTrimDown(tr[0]), .secondGearNumerator(cmd[0]), .syncRole(role),
		.tensionCmd(tens), .initialDiameterSel(dia), .fireModeSignal(g[1]),
		.tensionPidGroup2(g[0]));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic fn(input int t, input logic [6:0] c);
		apb(1'b1, OFF_FUNC_BASE + 12'(4 * t), {25'h0, c});
	endtask
	task automatic setT(input logic [5:0] v);
		want <= v;
		repeat (5) @(posedge mclk);
	endtask
	task automatic give_verdict;
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		rdc("fastType", OFF_FAST_TYPE, 32'h0);
		rdc("func0", OFF_FUNC_BASE, 32'h1);
		rdc("func1", OFF_FUNC_BASE + 12'h004, 32'h0);
		chk("fastAB", 32'h3, {fA, fB});
		rdc("unmapped", 12'h0fc, 32'h0);
		chk("slverr", 32'h1, err);
		setT(6'h01);
		chk("fwd", 32'h1, forward_rotation);
		foreach (codes[i]) begin
			fn(0, codes[i]);
			setT(6'h01);
			chk("cmd", 32'h200 >> i, cmd);
			setT(6'h00);
		end
		fn(0, FN_CYCLIC);
		fn(1, FN_SERVO);
		fn(2, FN_FIRE);
		fn(3, FN_TPID2);
		setT(6'h0f);
		chk("gateOff", 32'h0, g);
		apb(1'b1, OFF_CONTROL, 32'h1e);
		repeat (2) @(posedge mclk);
		chk("gateOn", 32'hf, g);
		for (int i = 0; i < 7; i++) begin
			fn(0, FN_DIA_RST + 7'(i));
			repeat (2) @(posedge mclk);
			chk("tension", 32'h1 << i, tens);
		end
		fn(1, FN_DIA_SEL1);
		repeat (2) @(posedge mclk);
		chk("diameter", 32'h2, dia);
		apb(1'b1, OFF_CONTROL, 32'h0);
		repeat (2) @(posedge mclk);
		chk("tensionOff", 32'h0, tens);
		fn(0, FN_PULSE_UP);
		fn(1, FN_PULSE_DN);
		fn(2, FN_SUPERIMP);
		setT(6'h03);
		chk("trimOff", 32'h0, tr);
		setT(6'h07);
		chk("trimOn", 32'h3, tr);
		fn(0, FN_CLOSED_LOOP);
		fn(1, FN_SLAVE);
		setT(6'h03);
		chk("modeRun", 32'h0, {mode, role});
		driveStopped <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("modeStop", 32'h6, {mode, role});
		fn(0, FN_OPEN_LOOP);
		fn(1, FN_MASTER);
		repeat (4) @(posedge mclk);
		chk("modeBack", 32'h1, {mode, role});
		rdc("status", OFF_STATUS, 32'h10);
		apb(1'b1, OFF_CONTROL, 32'h1);
		fn(0, FN_CLOSED_LOOP);
		fn(1, FN_SLAVE);
		repeat (4) @(posedge mclk);
		chk("modeLock", 32'h1, {mode, role});
		fn(4, FN_FWD_RUN);
		fn(5, FN_FWD_RUN);
		setT(6'h30);
		chk("fastPulse", 32'h0, forward_rotation);
		rdc("levels", OFF_LEVELS, 32'h30);
		apb(1'b1, OFF_FAST_TYPE, 32'h01);
		repeat (2) @(posedge mclk);
		chk("fastOnes", 32'h10, forward_rotation);
		apb(1'b1, OFF_FAST_TYPE, 32'h11);
		repeat (2) @(posedge mclk);
		chk("fastTens", 32'h30, forward_rotation);
		chk("fastType", 32'h0, {fA, fB});
		rdc("fastRead", OFF_FAST_TYPE, 32'h11);
		give_verdict;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		miscompares++;
		give_verdict;
	end
endmodule
`default_nettype wire
